// file: dv/peer_fifo_model.sv
// peer fifo behind the writer, drains one word every other cycle
`timescale 1ns/1ps
module peer_fifo_model
(
   input wire logic clk, // bench clock
   input wire logic rst_n, // async reset, active low
   input wire logic peer_wr, // word write strobe
   input wire logic [63:0] peer_data, // written word
   output logic [7:0] peer_room, // free words
   output int count, // words taken since reset
   output logic [63:0] first_word // first word after reset
);
   int held;
   logic tick;
   assign peer_room = 8'(255 - held);
   // slower drain than a combiner burst, so room really shrinks
   always_ff @(posedge clk or negedge rst_n)
      if (!rst_n)
      begin
         held <= 0;
         count <= 0;
         tick <= 0;
         first_word <= '0;
      end
      else
      begin
         tick <= !tick;
         held <= held + int'(peer_wr) - int'(tick && held > 0);
         count <= count + int'(peer_wr);
         if (peer_wr && count == 0)
            first_word <= peer_data;
      end
endmodule

// file: dv/rx_path_asserts.sv
// concurrent checks on the receive path ports
`timescale 1ns/1ps
module rx_path_asserts
   import rx_pack_pkg::*;
#(parameter int DLY_W = 16)
(
   input wire logic clk, // router clock
   input wire logic rst_n, // async reset, active low
   input wire logic calib_mode, // calibration mode
   input wire logic host_trig, // host start pulse
   input wire logic dist_trig, // distributed trigger
   input wire logic fe_valid, // sample strobe
   input wire logic [1:0] role, // head personality
   input wire logic [DLY_W-1:0] rx_delay, // receive delay
   input wire logic [7:0] peer_room, // peer free words
   input wire logic trig_fwd, // forwarded trigger
   input wire logic tx_start, // transmit start
   input wire logic rx_start, // receive start
   input wire logic tx_route_en, // transmit router on
   input wire logic rx_route_en, // receive router on
   input wire logic xf_in_valid, // body sample valid
   input wire logic xf_in_first, // first body sample
   input wire logic peer_wr, // word to peer
   input wire logic burst_busy // burst running
);
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!rst_n);
   sequence s_word;
      peer_wr && role != ROLE_COMBINER;
   endsequence
   sequence s_gap;
      !peer_wr [*7];
   endsequence
   property p_tx;
      dist_trig |=> tx_start;
   endproperty
   property p_fwd;
      host_trig && role == ROLE_COMBINER |=> trig_fwd;
   endproperty
   property p_nofwd;
      !(host_trig && role == ROLE_COMBINER) |=> !trig_fwd;
   endproperty
   property p_rx0;
      dist_trig && (calib_mode || rx_delay == '0) |=> rx_start;
   endproperty
   property p_route;
      1'b1 |=> tx_route_en == ($past(role) == ROLE_SPLITTER)
         && rx_route_en == ($past(role) == ROLE_COMBINER);
   endproperty
   property p_feed;
      xf_in_valid |-> $past(fe_valid);
   endproperty
   property p_first;
      xf_in_first |-> xf_in_valid;
   endproperty
   property p_rate;
      s_word |=> s_gap;
   endproperty
   property p_room;
      $rose(burst_busy) |-> $past(peer_room) >= 8'h40;
   endproperty
   a_tx: assert property (p_tx) else $error("no tx start");
   a_fwd: assert property (p_fwd) else $error("no forward");
   a_nofwd: assert property (p_nofwd) else $error("bad forward");
   a_rx0: assert property (p_rx0) else $error("no rx start");
   a_route: assert property (p_route) else $error("route en");
   a_feed: assert property (p_feed) else $error("stray valid");
   a_first: assert property (p_first) else $error("bad first");
   a_rate: assert property (p_rate) else $error("too fast");
   a_room: assert property (p_room) else $error("no room");
endmodule

// file: dv/test_radio_head_rx_path_packetizer.sv
// self-checking bench for the receive path and packetizer
`timescale 1ns/1ps
module test_radio_head_rx_path_packetizer;
   import rx_pack_pkg::*;
   logic clk = 0, rst_n = 0, calib_mode = 0, host_trig = 0, dist_trig = 0;
   logic fe_valid = 0, xf_out_valid = 0;
   logic [1:0] role = 0;
   logic [15:0] rx_delay = 0;
   logic [31:0] fe_a0 = 0, fe_a1 = 0, cap_a0, cap_a1, xf_in_a0, xf_in_a1;
   logic [23:0] xf_out_a0 = 0, xf_out_a1 = 0;
   logic [7:0] peer_room;
   logic trig_fwd, tx_start, rx_start, tx_route_en, rx_route_en, cap_valid;
   logic xf_in_valid, xf_in_first, xf_out_ready, peer_wr, burst_busy;
   logic [63:0] peer_data, first_word;
   int count, miscompares = 0, checked = 0, cycles = 0;
   radio_head_rx_path_packetizer dut_u (
      .clk(clk), .rst_n(rst_n), .role(role), .calib_mode(calib_mode),
      .rx_delay(rx_delay), .host_trig(host_trig), .dist_trig(dist_trig),
      .fe_valid(fe_valid), .fe_a0(fe_a0), .fe_a1(fe_a1),
      .xf_out_valid(xf_out_valid), .xf_out_a0(xf_out_a0),
      .xf_out_a1(xf_out_a1), .peer_room(peer_room), .trig_fwd(trig_fwd),
      .tx_start(tx_start), .rx_start(rx_start), .tx_route_en(tx_route_en),
      .rx_route_en(rx_route_en), .cap_valid(cap_valid), .cap_a0(cap_a0),
      .cap_a1(cap_a1), .xf_in_valid(xf_in_valid), .xf_in_first(xf_in_first),
      .xf_in_a0(xf_in_a0), .xf_in_a1(xf_in_a1), .xf_out_ready(xf_out_ready),
      .peer_wr(peer_wr), .peer_data(peer_data), .burst_busy(burst_busy));
   peer_fifo_model peer_u (.clk, .rst_n, .peer_wr, .peer_data, .peer_room,
      .count, .first_word);
   always #12.5 clk = ~clk;
   always @(posedge clk)
   begin
      cycles++;
      if (cycles == 10000)
      begin
         miscompares++;
         complete_run();
      end
   end
   task automatic complete_run;
      $display("miscompares %0d checked %0d", miscompares, checked);
      if (miscompares == 0 && checked > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask
   task automatic chk(input logic [63:0] got, exp);
      checked++;
      if (got !== exp)
      begin
         miscompares++;
         $display("wrong value t=%0t got %h exp %h", $time, got, exp);
      end
   endtask
   task automatic go(input logic [1:0] r, input logic c, input logic [15:0] d);
      @(posedge clk)
      begin
         rst_n <= 0;
         role <= r;
         calib_mode <= c;
         rx_delay <= d;
      end
      repeat (4) @(posedge clk);
      rst_n <= 1;
      @(posedge clk);
      #1;
   endtask
   task automatic trig;
      @(posedge clk) dist_trig <= 1;
      @(posedge clk) dist_trig <= 0;
      #1;
   endtask
   task automatic smp(input logic [31:0] s);
      @(posedge clk)
      begin
         fe_valid <= 1;
         fe_a0 <= s;
         fe_a1 <= ~s;
      end
      @(posedge clk) fe_valid <= 0;
      #1;
   endtask
   task automatic t_roles;
      for (int r = 0; r < 3; r++)
      begin
         go(2'(r), 0, 0);
         chk(tx_route_en, r == 2);
         chk(rx_route_en, r == 1);
         @(posedge clk) host_trig <= 1;
         @(posedge clk) host_trig <= 0;
         #1;
         chk(trig_fwd, r == 1);
      end
   endtask
   task automatic t_delay;
      go(ROLE_NORMAL, 0, 16'h0003);
      trig();
      chk(tx_start, 1);
      chk(rx_start, 0);
      smp(32'h1);
      smp(32'h2);
      chk(rx_start, 0);
      smp(32'h3);
      chk(rx_start, 1);
   endtask
   task automatic t_prefix;
      int n;
      n = 0;
      go(ROLE_NORMAL, 1, 0);
      trig();
      chk(rx_start, 1);
      for (int i = 0; i < 160; i++)
      begin
         smp(32'(i + 9));
         n += int'(xf_in_valid);
         if (i == 0)
         begin
            chk({cap_valid, cap_a0}, 33'h100000009);
            chk(cap_a1, 32'hfffffff6);
         end
      end
      chk(64'(n), 0);
      smp(32'h00050007);
      chk({xf_in_valid, xf_in_first, xf_in_a0}, 34'h300050007);
      chk(xf_in_a1, 32'hfffafff8);
      smp(32'h00050007);
      chk({xf_in_valid, xf_in_first, xf_in_a0}, 34'h2fffbfff9);
      chk(xf_in_a1, 32'h00060008);
   endtask
   task automatic t_burst(input logic [1:0] r);
      int w;
      logic rdy;
      go(r, 0, 0);
      // bins 424..519 kept: 24 groups, 72 words, one burst
      @(posedge clk);
      for (int b = 0; b < 520; b++)
      begin
         xf_out_valid <= 1;
         xf_out_a0 <= 24'(b);
         xf_out_a1 <= 24'(b) | 24'h800000;
         // ready read once settled; it holds until the edge that takes the bin
         do
         begin
            #1 rdy = xf_out_ready;
            @(posedge clk);
         end
         while (rdy !== 1'b1);
      end
      xf_out_valid <= 0;
      w = 0;
      while (count < 64 && w < 900)
      begin
         @(posedge clk);
         w++;
      end
      repeat (40) @(posedge clk);
      chk(64'(count), 64);
      chk(first_word, 64'h0001a88001a80001);
   endtask
   initial
   begin
      t_roles();
      t_delay();
      t_prefix();
      t_burst(ROLE_COMBINER);
      t_burst(ROLE_NORMAL);
      complete_run();
   end
endmodule
bind radio_head_rx_path_packetizer rx_path_asserts #(.DLY_W(DLY_W)) chk_u (
   .clk(clk), .rst_n(rst_n), .calib_mode(calib_mode), .host_trig(host_trig),
   .dist_trig(dist_trig), .fe_valid(fe_valid), .role(role),
   .rx_delay(rx_delay), .peer_room(peer_room), .trig_fwd(trig_fwd),
   .tx_start(tx_start), .rx_start(rx_start), .tx_route_en(tx_route_en),
   .rx_route_en(rx_route_en), .xf_in_valid(xf_in_valid),
   .xf_in_first(xf_in_first), .peer_wr(peer_wr), .burst_busy(burst_busy));

// file: logic/radio_head_rx_path_packetizer.sv
// receive path: symbol alignment, prefix removal, transform feed, packing
`timescale 1ns/1ps
module radio_head_rx_path_packetizer
   import rx_pack_pkg::*;
#(
   parameter int SW = 16,
   parameter int DEPTH = 128,
   parameter int DLY_W = 16
)
(
   input wire logic clk, // single clock, router rate
   input wire logic rst_n, // async reset, active low
   input wire logic [1:0] role, // head personality
   input wire logic calib_mode, // loopback calibration, delay forced to 0
   input wire logic [DLY_W-1:0] rx_delay, // calibrated delay in samples
   input wire logic host_trig, // start pulse from host
   input wire logic dist_trig, // distributed trigger, all heads
   input wire logic fe_valid, // sample strobe from sample_front_end
   input wire logic [2*SW-1:0] fe_a0, // antenna 0 sample {i,q}
   input wire logic [2*SW-1:0] fe_a1, // antenna 1 sample {i,q}
   input wire logic xf_out_valid, // transform output bin valid
   input wire logic [SYM_W-1:0] xf_out_a0, // antenna 0 bin {i,q}
   input wire logic [SYM_W-1:0] xf_out_a1, // antenna 1 bin {i,q}
   input wire logic [7:0] peer_room, // free words in peer FIFO
   output logic trig_fwd, // forwarded trigger, entry head only
   output logic tx_start, // transmit frame start pulse
   output logic rx_start, // receive frame start pulse
   output logic tx_route_en, // transmit router enabled
   output logic rx_route_en, // receive router enabled
   output logic cap_valid, // raw capture strobe in calibration
   output logic [2*SW-1:0] cap_a0, // raw antenna 0 sample
   output logic [2*SW-1:0] cap_a1, // raw antenna 1 sample
   output logic xf_in_valid, // body sample into transform
   output logic xf_in_first, // first sample of a transform block
   output logic [2*SW-1:0] xf_in_a0, // antenna 0, alternately negated
   output logic [2*SW-1:0] xf_in_a1, // antenna 1, alternately negated
   output logic xf_out_ready, // bins accepted
   output logic peer_wr, // one word into peer FIFO
   output logic [WORD_W-1:0] peer_data, // word to peer FIFO
   output logic burst_busy // burst in progress
);
   localparam int AW = $clog2(DEPTH);

   // elaboration checks: parameters the logic cannot serve
   if (DEPTH < BURST_WORDS + GROUP_WORDS || (1 << AW) != DEPTH)
      $error("DEPTH must be a power of two of at least 67");
   if (SW < 2 || DLY_W < 1)
      $error("SW or DLY_W too small");
   // the 11-bit bin counter wraps exactly once per block
   if (FFT_N != (1 << 11))
      $error("bin counter sized for another block length");
   // one burst must be the full staging chunk
   if (BURST_BYTES != BURST_WORDS * WORD_W / 8)
      $error("burst size and word width disagree");
   if (2 * GROUP_SC * SYM_W != GROUP_WORDS * WORD_W)
      $error("a group must fill its words exactly");
   // single clock must keep up with one sample per cycle
   if (SAMPLE_KHZ > ROUTER_MHZ * 1000)
      $error("clock slower than sample rate");
   // one slot in eight stays under the payload share
   if (100 > PAYLOAD_PCT * (int'(THROTTLE_LAST) + 1))
      $error("throttle slot exceeds payload share");

   typedef struct packed {
      logic trig_fwd;
      logic tx_start;
      logic rx_start;
      logic tx_route_en;
      logic rx_route_en;
      logic dly_busy;
      logic [DLY_W-1:0] dly_cnt;
      logic frame_run;
      logic cap_valid;
      logic [2*SW-1:0] cap_a0;
      logic [2*SW-1:0] cap_a1;
      logic [11:0] pos;
      logic [3:0] sym;
      logic neg;
      logic xf_valid;
      logic xf_first;
      logic [2*SW-1:0] xf_a0;
      logic [2*SW-1:0] xf_a1;
      logic xf_ready;
      logic [10:0] bin;
      logic [GROUP_WORDS*WORD_W-1:0] pk;
      logic [1:0] pk_n;
      logic [1:0] emit;
      logic [DEPTH-1:0][WORD_W-1:0] mem;
      logic [AW:0] wr_ptr;
      logic [AW:0] rd_ptr;
      logic [AW:0] cnt;
      logic [6:0] burst_left;
      logic [2:0] thr;
      logic peer_wr;
      logic [WORD_W-1:0] peer_data;
      logic busy;
   } state_t;

   state_t st;
   state_t next_st;

   // negate both halves of an {i,q} sample; the most negative code wraps
   function automatic logic [2*SW-1:0] negate_iq(input logic [2*SW-1:0] s);
      negate_iq = {SW'(-s[2*SW-1:SW]), SW'(-s[SW-1:0])};
   endfunction

   function automatic logic is_combiner(input logic [1:0] r);
      is_combiner = (r == ROLE_COMBINER);
   endfunction

   function automatic logic used_bin(input logic [10:0] b);
      used_bin = (b >= USED_LO) && (b <= USED_HI) && (b != DC_BIN);
   endfunction

   logic [11:0] cp_len;
   logic body;
   logic fe_take;
   logic bin_take;
   logic push;
   logic pop;
   logic burst_go;
   logic tick;

   always_comb
   begin
      next_st = st;
      cp_len = (st.sym == 4'h0) ? CP_LONG : CP_SHORT;
      body = st.pos >= cp_len;
      fe_take = fe_valid && st.frame_run;
      bin_take = xf_out_valid && st.xf_ready;
      push = 1'b0;
      pop = 1'b0;
      burst_go = 1'b0;
      tick = 1'b0;

      // personality gating of routers
      // role selects router
      next_st.tx_route_en = (role == ROLE_SPLITTER);
      next_st.rx_route_en = is_combiner(role);

      next_st.trig_fwd = host_trig && is_combiner(role);

      // every head starts on the same distributed edge
      // common trigger cycle
      next_st.tx_start = dist_trig;
      next_st.rx_start = 1'b0;
      // a new trigger restarts count and framing, never stacks two starts
      // receive start after delay
      if (dist_trig)
      begin
         if (calib_mode || rx_delay == '0)
         begin
            next_st.rx_start = 1'b1;
            next_st.frame_run = 1'b1;
            next_st.dly_busy = 1'b0;
         end
         else
         begin
            next_st.dly_busy = 1'b1;
            next_st.dly_cnt = rx_delay;
            next_st.frame_run = 1'b0;
         end
         next_st.pos = '0;
         next_st.sym = '0;
         next_st.neg = 1'b0;
      end
      else if (st.dly_busy && fe_valid)
      begin
         next_st.dly_cnt = st.dly_cnt - DLY_W'(1);
         if (st.dly_cnt == DLY_W'(1))
         begin
            next_st.dly_busy = 1'b0;
            next_st.frame_run = 1'b1;
            next_st.rx_start = 1'b1;
         end
      end

      next_st.cap_valid = fe_take && calib_mode;
      if (fe_take)
      begin
         next_st.cap_a0 = fe_a0;
         next_st.cap_a1 = fe_a1;
      end

      // symbol alignment and prefix removal
      next_st.xf_valid = 1'b0;
      next_st.xf_first = 1'b0;
      if (fe_take && !dist_trig)
      begin
         if (st.pos == cp_len + BODY_LAST)
         begin
            next_st.pos = '0;
            next_st.neg = 1'b0;
            next_st.sym = (st.sym == SYMS_PER_SLOT - 4'h1) ? 4'h0
                        : st.sym + 4'h1;
         end
         else
            next_st.pos = st.pos + 12'h1;
         next_st.xf_valid = body;
         next_st.xf_first = (st.pos == cp_len);
         if (body)
         begin
            next_st.neg = !st.neg;
            next_st.xf_a0 = st.neg ? negate_iq(fe_a0) : fe_a0;
            next_st.xf_a1 = st.neg ? negate_iq(fe_a1) : fe_a1;
         end
      end

      // transform output bins, counted per block
      if (bin_take)
      begin
         next_st.bin = st.bin + 11'h1;
         if (used_bin(st.bin))
         begin
            next_st.pk = {st.pk[GROUP_WORDS*WORD_W-2*SYM_W-1:0],
                          xf_out_a0, xf_out_a1};
            next_st.pk_n = st.pk_n + 2'h1;
            if (st.pk_n == 2'(GROUP_SC - 1))
               next_st.emit = 2'(GROUP_WORDS);
         end
      end
      else if (st.emit != 2'h0 && st.cnt < (AW+1)'(DEPTH))
      begin
         push = 1'b1;
         next_st.pk = {st.pk[GROUP_WORDS*WORD_W-WORD_W-1:0],
                       {WORD_W{1'b0}}};
         next_st.emit = st.emit - 2'h1;
      end

      // free-running phase: a burst's first word may wait up to seven cycles
      // throttle: combiner every cycle, others one slot in eight
      // rate limiter
      next_st.thr = st.thr + 3'h1;
      tick = is_combiner(role) || (st.thr == THROTTLE_LAST);

      burst_go = (st.burst_left == 7'h0) &&
                 (st.cnt >= (AW+1)'(BURST_WORDS)) &&
                 (peer_room >= 8'(BURST_WORDS));
      if (burst_go)
         next_st.burst_left = 7'(BURST_WORDS);
      // one word per clock at most
      pop = (st.burst_left != 7'h0) && tick;
      next_st.peer_wr = pop;
      if (pop)
      begin
         next_st.peer_data = st.mem[st.rd_ptr[AW-1:0]];
         next_st.rd_ptr = st.rd_ptr + (AW+1)'(1);
         next_st.burst_left = st.burst_left - 7'h1;
      end
      if (push)
      begin
         next_st.mem[st.wr_ptr[AW-1:0]] =
            st.pk[GROUP_WORDS*WORD_W-1 -: WORD_W];
         next_st.wr_ptr = st.wr_ptr + (AW+1)'(1);
      end
      next_st.cnt = st.cnt + (AW+1)'(push) - (AW+1)'(pop);
      next_st.busy = (next_st.burst_left != 7'h0);

      // registered ready leaves room for a full group of three words
      next_st.xf_ready = (next_st.emit == 2'h0) &&
                         (next_st.cnt <= (AW+1)'(DEPTH - GROUP_WORDS));
   end

   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
         st <= '0;
      else
         st <= next_st;
   end

   // invalid samples never reach the transform
   assign xf_in_valid = st.xf_valid;
   assign xf_in_first = st.xf_first;
   assign xf_in_a0 = st.xf_a0;
   assign xf_in_a1 = st.xf_a1;
   assign xf_out_ready = st.xf_ready;
   assign trig_fwd = st.trig_fwd;
   assign tx_start = st.tx_start;
   assign rx_start = st.rx_start;
   assign tx_route_en = st.tx_route_en;
   assign rx_route_en = st.rx_route_en;
   assign cap_valid = st.cap_valid;
   assign cap_a0 = st.cap_a0;
   assign cap_a1 = st.cap_a1;
   assign peer_wr = st.peer_wr;
   assign peer_data = st.peer_data;
   assign burst_busy = st.busy;
endmodule

// file: logic/rx_pack_pkg.sv
// shared constants for the radio head receive path and packetizer
// Operation
// - staging FIFO per peer writer; 64-word bursts only when staged and peer has room
// - routing logic runs on the single 105 MHz router clock shared with the receive path
// - router moves at most one 64-bit word per router clock
// - non-combiner heads emit at most one word per 8 router clocks
// - throttling keeps payload at or below 80 percent of link rate; combiner heads are unthrottled, one word per router clock
// - host fills transmit chains then triggers entry head, which forwards it
// - all heads take the distributed trigger in one cycle and start together
// - receive frame start is transmit frame start plus configured delay
// - receive side starts calibrated samples after transmit side
// - calibration runs loopback with zero delay, capturing raw received values
// - buffer takes samples, tags symbol start and valid, delivers consecutive symbols
// - prefix removal clears valid on every cyclic-prefix sample
// - transform converts each block of 2048 valid samples
// - alternate inputs negated so zero frequency lands on bin 1024
// - extraction keeps only the 1200 used subcarriers
// - packer joins both antennas' subcarriers and hands words to router
// - transmit routing only as splitter, receive routing only as combiner
// - each frequency symbol is 24 bits, 12 in-phase and 12 quadrature
// - four subcarriers of two antennas pack into three 64-bit words
package rx_pack_pkg;
   localparam int ROUTER_MHZ = 105;
   localparam int SAMPLE_KHZ = 30720;
   localparam int PAYLOAD_PCT = 80;
   localparam int FFT_N = 2048;
   localparam logic [10:0] DC_BIN = 11'h400;
   localparam int USED_SC = 1200;
   localparam logic [10:0] USED_LO = 11'(1024 - USED_SC / 2);
   localparam logic [10:0] USED_HI = 11'(1024 + USED_SC / 2);
   localparam int IQ_W = 12;
   localparam int SYM_W = 2 * IQ_W;
   localparam int WORD_W = 64;
   localparam int GROUP_SC = 4;
   localparam int GROUP_WORDS = 3;
   localparam int BURST_WORDS = 64;
   localparam int BURST_BYTES = 512;
   localparam logic [2:0] THROTTLE_LAST = 3'h7;
   localparam logic [11:0] CP_LONG = 12'ha0;
   localparam logic [11:0] CP_SHORT = 12'h90;
   localparam logic [3:0] SYMS_PER_SLOT = 4'h7;
   localparam logic [11:0] BODY_LAST = 12'h7ff;
   localparam logic [1:0] ROLE_NORMAL = 2'h0;
   localparam logic [1:0] ROLE_COMBINER = 2'h1;
   localparam logic [1:0] ROLE_SPLITTER = 2'h2;
endpackage
